// >>> cmc_comparator.sv
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// What this block does
// - Raw result high when noninverting input higher
// - Enable bit activates comparator; clear powers down
// - Two-bit field selects one of four pins
// - Reference bit picks internal reference or pin
// - Pin driven only with enable, OE, direction
// - Pin output enable overrides port data latch
// - Internal result registered each instruction cycle
// - Polarity bit one inverts the reported result
// - Speed bit resets to one, zero low-power
// - Flag sets on output change via latches
// - First latch loads phase three on access
// - First latch holds until next access, reset
// - Second latch samples output every phase one
// - Mismatch is XOR of both latches
// - Control write also clears mismatch condition
// - Mismatch works regardless of pin output enable
// - Flag set on mismatch rising edge
// - Software writes zero clears, one sets flag
// - Interrupt needs enable, peripheral, global gates
// - Disabled comparator feeds zero to polarity stage
// - Phase-one strobe held high during sleep
// - Result mirrored in shared second register
module cmc_comparator (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Analog front end.
   input  wire logic        cmp_raw_async,
   output logic             cmp_power_on,
   output logic             cmp_high_speed,
   output logic [3:0]       inv_input_route,
   output logic             noninv_route_ref,
   // Port pin and system.
   input  wire logic        pin_direction_bit,
   input  wire logic        sleep_mode,
   output logic             port_override,
   output logic             cmp_pin_out,
   output logic             cmp_pin_oe,
   output logic             cmp_irq
);

   cmc_pkg::cmc_state_type s_r;
   cmc_pkg::cmc_state_type s_nxt;
   logic                   raw_meta_r;
   logic                   raw_sync_r;
   logic                   cmp_result;
   logic                   raw_gated;
   logic                   phase_one_strobe;
   logic                   phase_three_strobe;
   logic                   mismatch;
   logic                   take;
   logic [31:0]            rd_word;

   // The comparator output is asynchronous to hclk.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         raw_meta_r <= 1'b0;
         raw_sync_r <= 1'b0;
      end else begin
         raw_meta_r <= cmp_raw_async;
         raw_sync_r <= raw_meta_r;
      end
   end

   assign raw_gated = s_r.ctrl.enable & raw_sync_r;
   assign cmp_result = raw_gated ^ s_r.ctrl.output_invert;
   assign phase_one_strobe = (s_r.phase == cmc_pkg::PHASE_ONE) | sleep_mode;
   assign phase_three_strobe = (s_r.phase == cmc_pkg::PHASE_THREE);
   assign mismatch = s_r.latch_first ^ s_r.latch_second;
   assign take = hsel & hready & (htrans == cmc_pkg::HTRANS_NONSEQ
                                  | htrans == cmc_pkg::HTRANS_SEQ);

   always_comb begin
      rd_word = 32'h0000_0000;
      // Decoded in the address phase so that hrdata stands through the data phase.
      case (haddr[7:0])
         cmc_pkg::ADDR_CTRL: begin
            rd_word[cmc_pkg::CTRL_ENABLE_BIT]  = s_r.ctrl.enable;
            rd_word[cmc_pkg::CTRL_RESULT_BIT]  = s_r.latch_second;
            rd_word[cmc_pkg::CTRL_PIN_OE_BIT]  = s_r.ctrl.pin_out_enable;
            rd_word[cmc_pkg::CTRL_INVERT_BIT]  = s_r.ctrl.output_invert;
            rd_word[cmc_pkg::CTRL_SPEED_BIT]   = s_r.ctrl.speed_power_select;
            rd_word[cmc_pkg::CTRL_REF_SEL_BIT] = s_r.ctrl.noninv_ref_select;
            rd_word[cmc_pkg::CTRL_CH_LSB +: 2] = s_r.ctrl.inv_input_select;
         end
         cmc_pkg::ADDR_SHARED: rd_word[cmc_pkg::SHARED_MIRROR_BIT] = s_r.latch_second;
         cmc_pkg::ADDR_FLAG:   rd_word[cmc_pkg::FLAG_BIT] = s_r.irq_flag;
         cmc_pkg::ADDR_IRQ_EN: rd_word[cmc_pkg::IRQ_EN_BIT] = s_r.irq_enable;
         cmc_pkg::ADDR_IRQ_CTL: begin
            rd_word[cmc_pkg::IRQ_PERIPH_BIT] = s_r.periph_gate;
            rd_word[cmc_pkg::IRQ_GLOBAL_BIT] = s_r.global_gate;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.phase = s_r.phase + 2'h1;
      s_nxt.ap.valid = take;
      if (take) begin
         s_nxt.ap.write = hwrite;
         s_nxt.ap.addr  = haddr[7:0];
      end
      if (take && !hwrite) begin
         s_nxt.rdata = rd_word;
      end
      if (phase_three_strobe && s_r.ctrl_access) begin
         s_nxt.latch_first = cmp_result;
         s_nxt.ctrl_access = 1'b0;
      end
      // Access to the control register is remembered until phase three.
      // A new access in the loading cycle stays pending for the next phase three.
      if (s_r.ap.valid && s_r.ap.addr == cmc_pkg::ADDR_CTRL) begin
         s_nxt.ctrl_access = 1'b1;
      end
      if (phase_one_strobe) begin
         s_nxt.latch_second = cmp_result;
      end
      s_nxt.mismatch_d = mismatch;
      if (s_r.ap.valid && s_r.ap.write) begin
         case (s_r.ap.addr)
            cmc_pkg::ADDR_CTRL: begin
               s_nxt.ctrl.enable             = hwdata[cmc_pkg::CTRL_ENABLE_BIT];
               s_nxt.ctrl.pin_out_enable     = hwdata[cmc_pkg::CTRL_PIN_OE_BIT];
               s_nxt.ctrl.output_invert      = hwdata[cmc_pkg::CTRL_INVERT_BIT];
               s_nxt.ctrl.speed_power_select = hwdata[cmc_pkg::CTRL_SPEED_BIT];
               s_nxt.ctrl.noninv_ref_select  = hwdata[cmc_pkg::CTRL_REF_SEL_BIT];
               s_nxt.ctrl.inv_input_select   = hwdata[cmc_pkg::CTRL_CH_LSB +: 2];
            end
            cmc_pkg::ADDR_FLAG:   s_nxt.irq_flag = hwdata[cmc_pkg::FLAG_BIT];
            cmc_pkg::ADDR_IRQ_EN: s_nxt.irq_enable = hwdata[cmc_pkg::IRQ_EN_BIT];
            cmc_pkg::ADDR_IRQ_CTL: begin
               s_nxt.periph_gate = hwdata[cmc_pkg::IRQ_PERIPH_BIT];
               s_nxt.global_gate = hwdata[cmc_pkg::IRQ_GLOBAL_BIT];
            end
            default: s_nxt.irq_flag = s_r.irq_flag;
         endcase
      end
      // A hardware set wins over a software clear in the same cycle.
      if (mismatch && !s_r.mismatch_d) begin
         s_nxt.irq_flag = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '{ctrl: cmc_pkg::cmc_ctrl_type'({cmc_pkg::CTRL_RESET[7],
                                                 cmc_pkg::CTRL_RESET[5:0]}),
                  ap: '0, phase: 2'h0,
                  latch_first: 1'b0, latch_second: 1'b0, mismatch_d: 1'b0,
                  irq_flag: 1'b0, irq_enable: 1'b0, periph_gate: 1'b0,
                  global_gate: 1'b0, ctrl_access: 1'b0, rdata: 32'h0000_0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign hrdata           = s_r.rdata;
   assign cmp_power_on     = s_r.ctrl.enable;
   assign cmp_high_speed   = s_r.ctrl.speed_power_select;
   assign noninv_route_ref = s_r.ctrl.noninv_ref_select;
   assign inv_input_route  = 4'h1 << s_r.ctrl.inv_input_select;
   assign port_override    = s_r.ctrl.pin_out_enable;
   assign cmp_pin_oe       = s_r.ctrl.pin_out_enable & ~pin_direction_bit
                             & s_r.ctrl.enable;
   assign cmp_pin_out      = cmp_pin_oe & cmp_result;
   assign cmp_irq          = s_r.irq_flag & s_r.irq_enable & s_r.periph_gate
                             & s_r.global_gate;

   AST_RESET_SPEED: assert property (@(posedge hclk)
      $rose(hresetn) |-> s_r.ctrl.speed_power_select)
      else $error("speed select not one after reset");
   AST_PIN_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
      cmp_pin_oe |-> s_r.ctrl.enable && s_r.ctrl.pin_out_enable && !pin_direction_bit)
      else $error("pin driven without all three conditions");
   AST_DISABLED_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_r.ctrl.enable |-> cmp_result == s_r.ctrl.output_invert)
      else $error("disabled comparator result not equal polarity");
   AST_SECOND_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
      phase_one_strobe |=> s_r.latch_second == $past(cmp_result))
      else $error("second latch missed phase one sample");
   AST_FIRST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      !(phase_three_strobe && s_r.ctrl_access) |=> $stable(s_r.latch_first))
      else $error("first latch changed without access");
   AST_FLAG_ON_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
      (mismatch && !s_r.mismatch_d) |=> s_r.irq_flag)
      else $error("flag not set on mismatch edge");
   AST_ACCESS_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_r.ap.valid && s_r.ap.addr == cmc_pkg::ADDR_CTRL) |-> ##[1:4] phase_three_strobe
      ##1 (s_r.latch_first == $past(cmp_result)))
      else $error("first latch not loaded after control access");
   AST_IRQ_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
      cmp_irq |-> s_r.irq_flag && s_r.irq_enable && s_r.periph_gate && s_r.global_gate)
      else $error("interrupt raised with a gate closed");
   AST_SLEEP_STROBE: assert property (@(posedge hclk) disable iff (!hresetn)
      sleep_mode |-> phase_one_strobe)
      else $error("phase one strobe low in sleep");

   COV_FLAG_SET: cover property (@(posedge hclk) disable iff (!hresetn) $rose(s_r.irq_flag));
   COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn) $rose(cmp_irq));
   COV_PIN: cover property (@(posedge hclk) disable iff (!hresetn) cmp_pin_oe && cmp_pin_out);
   COV_CLEAR: cover property (@(posedge hclk) disable iff (!hresetn) $fell(mismatch));

endmodule

// >>> cmc_pkg.sv
package cmc_pkg;

   // Register byte addresses on the AHB-Lite bus.
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_SHARED  = 8'h04;
   localparam logic [7:0] ADDR_FLAG    = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN  = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CTL = 8'h10;

   // Field positions in the control, shared, flag and interrupt registers.
   localparam int CTRL_ENABLE_BIT   = 7;
   localparam int CTRL_RESULT_BIT   = 6;
   localparam int CTRL_PIN_OE_BIT   = 5;
   localparam int CTRL_INVERT_BIT   = 4;
   localparam int CTRL_SPEED_BIT    = 3;
   localparam int CTRL_REF_SEL_BIT  = 2;
   localparam int CTRL_CH_LSB       = 0;
   localparam int SHARED_MIRROR_BIT = 0;
   localparam int FLAG_BIT          = 0;
   localparam int IRQ_EN_BIT        = 0;
   localparam int IRQ_PERIPH_BIT    = 6;
   localparam int IRQ_GLOBAL_BIT    = 7;

   // Control register reset value: speed select set, all else clear.
   localparam logic [7:0] CTRL_RESET = 8'h08;

   // Four-phase system clock: phase counter values of the strobes.
   localparam logic [1:0] PHASE_ONE   = 2'h0;
   localparam logic [1:0] PHASE_THREE = 2'h2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;

   typedef struct packed {
      logic       enable;
      logic       pin_out_enable;
      logic       output_invert;
      logic       speed_power_select;
      logic       noninv_ref_select;
      logic [1:0] inv_input_select;
   } cmc_ctrl_type;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } cmc_aphase_type;

   typedef struct packed {
      cmc_ctrl_type   ctrl;
      cmc_aphase_type ap;
      logic [1:0]     phase;
      logic           latch_first;
      logic           latch_second;
      logic           mismatch_d;
      logic           irq_flag;
      logic           irq_enable;
      logic           periph_gate;
      logic           global_gate;
      logic           ctrl_access;
      logic [31:0]    rdata;
   } cmc_state_type;

endpackage

// >>> cmc_tb.sv
`timescale 1ns/1ns
module tb;
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic        hwrite  = 1'b0;
   logic        raw     = 1'b0;
   logic        dir     = 1'b0;
   logic        slp     = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] r;
   logic [3:0]  route;
   logic        hready, hresp, pwr, hs, nref, povr, pout, poe, irq;
   int          errors   = 0;
   int          n_checks = 0;
   int          cyc      = 0;

   always #10 hclk = ~hclk;

   cmc_comparator DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .cmp_raw_async(raw),
      .cmp_power_on(pwr), .cmp_high_speed(hs), .inv_input_route(route),
      .noninv_route_ref(nref), .pin_direction_bit(dir), .sleep_mode(slp),
      .port_override(povr), .cmp_pin_out(pout), .cmp_pin_oe(poe), .cmp_irq(irq));

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // A hang is cut short here and counted as an error.
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errors++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      htrans <= cmc_pkg::HTRANS_NONSEQ;
      haddr  <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(a, 1'b0, 32'h0, d);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic test_reset();
      rd(cmc_pkg::ADDR_CTRL, r);
      chk(r, 32'h08);
      chk_pin(hs, 1'b1);
      chk_pin(pwr, 1'b0);
      chk_pin(hresp, 1'b0);
      rd(8'h20, r);
      chk(r, 32'h0);
   endtask

   task automatic test_route();
      for (int c = 0; c < 4; c++) begin
         wr(cmc_pkg::ADDR_CTRL, 32'h80 | c | (c[0] << 2));
         idle(2);
         chk_pin(pwr, 1'b1);
         chk({28'h0, route}, 32'h1 << c);
         chk_pin(nref, c[0]);
         chk_pin(hs, 1'b0);
      end
      wr(cmc_pkg::ADDR_CTRL, 32'h08);
      idle(2);
      chk_pin(pwr, 1'b0);
   endtask

   task automatic test_result();
      logic res;
      for (int i = 0; i < 8; i++) begin
         raw <= i[0];
         wr(cmc_pkg::ADDR_CTRL, {24'h0, i[2], 2'b00, i[1], 4'h8});
         idle(12);
         res = (i[2] & i[0]) ^ i[1];
         rd(cmc_pkg::ADDR_CTRL, r);
         chk(r, {24'h0, i[2], res, 1'b0, i[1], 4'h8});
         rd(cmc_pkg::ADDR_SHARED, r);
         chk(r, {31'h0, res});
      end
   endtask

   task automatic test_pin();
      for (int j = 0; j < 8; j++) begin
         raw <= 1'b1;
         dir <= j[0];
         wr(cmc_pkg::ADDR_CTRL, {24'h0, j[2], 1'b0, j[1], 5'h08});
         idle(12);
         chk_pin(poe, j[2] & j[1] & ~j[0]);
         chk_pin(pout, j[2] & j[1] & ~j[0]);
         chk_pin(povr, j[1]);
      end
      dir <= 1'b0;
   endtask

   task automatic flag_is(input logic v);
      idle(12);
      rd(cmc_pkg::ADDR_FLAG, r);
      chk(r, {31'h0, v});
   endtask

   task automatic test_irq();
      raw <= 1'b0;
      wr(cmc_pkg::ADDR_CTRL, 32'hA8);
      idle(12);
      rd(cmc_pkg::ADDR_CTRL, r);
      idle(6);
      wr(cmc_pkg::ADDR_FLAG, 32'h0);
      flag_is(1'b0);
      raw <= 1'b1;
      flag_is(1'b1);
      wr(cmc_pkg::ADDR_FLAG, 32'h0);
      flag_is(1'b0);
      raw <= 1'b0;
      flag_is(1'b0);
      slp <= 1'b1;
      raw <= 1'b1;
      flag_is(1'b1);
      slp <= 1'b0;
      wr(cmc_pkg::ADDR_FLAG, 32'h0);
      rd(cmc_pkg::ADDR_CTRL, r);
      idle(6);
      raw <= 1'b0;
      flag_is(1'b1);
      wr(cmc_pkg::ADDR_FLAG, 32'h0);
      wr(cmc_pkg::ADDR_CTRL, 32'hA8);
      idle(6);
      raw <= 1'b1;
      flag_is(1'b1);
      wr(cmc_pkg::ADDR_FLAG, 32'h0);
      wr(cmc_pkg::ADDR_FLAG, 32'h1);
      flag_is(1'b1);
   endtask

   task automatic test_gates();
      for (int i = 0; i < 8; i++) begin
         wr(cmc_pkg::ADDR_IRQ_EN, {31'h0, i[0]});
         wr(cmc_pkg::ADDR_IRQ_CTL, {24'h0, i[2], i[1], 6'h0});
         idle(1);
         chk_pin(irq, i[0] & i[1] & i[2]);
      end
      wr(cmc_pkg::ADDR_FLAG, 32'h0);
      idle(1);
      chk_pin(irq, 1'b0);
   endtask

   initial begin
      idle(2);
      hresetn <= 1'b1;
      test_reset();
      test_route();
      test_result();
      test_pin();
      test_irq();
      test_gates();
      close_out();
   end
endmodule
